// [src/swcfg_pkg.sv]
// Purpose: Shared constants, types and the polling period table for the
//          switch-input low-power, wake-up and interrupt configuration bank.
// Assumes: 40 MHz reference clock; 32-bit serial frames, address on top.
// Notes:   Notes on behaviour below, placed beside the logic that carries it out.

package swcfg_pkg;

   localparam int unsigned FRAME_W   = 32;
   localparam int unsigned ADDR_W    = 7;
   localparam int unsigned DATA_W    = 22;
   localparam int unsigned BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h1F;
   localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 5'h00;

   localparam int unsigned GROUND_N = 14;
   localparam int unsigned PROG_N   = 8;
   localparam int unsigned POLL_W   = 4;
   localparam int unsigned MS_W     = 8;

   // Type bit value that marks a write
   localparam logic TYPE_WRITE = 1'b1;

   // Printed offsets: address shifted left over the type bit
   localparam logic [7:0] OFF_PROG_IRQ_EN   = 8'h1A;
   localparam logic [7:0] OFF_GROUND_IRQ_EN = 8'h1C;
   localparam logic [7:0] OFF_POLL_CFG      = 8'h1E;
   localparam logic [7:0] OFF_PROG_WAKE     = 8'h20;
   localparam logic [7:0] OFF_GROUND_WAKE   = 8'h22;
   localparam logic [7:0] OFF_PROG_CMP_ONLY = 8'h24;

   // Reset values
   localparam logic [13:0] RST_GROUND_IRQ_EN = 14'h3FFF;
   localparam logic [7:0]  RST_PROG_IRQ_EN   = 8'hFF;
   localparam logic [3:0]  RST_POLL_CODE     = 4'hF;
   localparam logic [7:0]  RST_PROG_WAKE     = 8'hFF;
   localparam logic [13:0] RST_GROUND_WAKE   = 14'h3FFF;
   localparam logic [7:0]  RST_PROG_CMP_ONLY = 8'h00;

   // Timebase: one millisecond in reference clock cycles
   localparam longint unsigned REF_CLK_PERIOD_PS = 25000;
   localparam longint unsigned ONE_MS_PS         = 64'd1000000000;
   localparam int unsigned     MS_CYC_DEF        = int'(ONE_MS_PS / REF_CLK_PERIOD_PS);

   // Serial frame, shared by command and reply
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              wr;
      logic              fault;
      logic              pend;
      logic [DATA_W-1:0] data;
   } swcfg_frame_t;

   // Poll period in milliseconds for each code
   function automatic logic [MS_W-1:0] swcfg_poll_ms(input logic [POLL_W-1:0] code);
      logic [MS_W-1:0] ms;
      ms = 8'h40;
      case (code)
         4'h0: ms = 8'h03;
         4'h1: ms = 8'h06;
         4'h2: ms = 8'h0C;
         4'h3: ms = 8'h18;
         4'h4: ms = 8'h30;
         4'h5: ms = 8'h44;
         4'h6: ms = 8'h4C;
         4'h7: ms = 8'h80;
         4'h8: ms = 8'h20;
         4'h9: ms = 8'h24;
         4'hA: ms = 8'h28;
         4'hB: ms = 8'h2C;
         4'hC: ms = 8'h34;
         4'hD: ms = 8'h34;
         4'hE: ms = 8'h38;
         default: ms = 8'h40;
      endcase
      return ms;
   endfunction : swcfg_poll_ms

endpackage : swcfg_pkg

// [src/swcfg_poll_timer.sv]
// Purpose: Low-power polling timer, one tick per selected poll period.
// Assumes: run is a level from the reference clock domain.
// Notes:   Counters clear whenever run drops, so a restart gives a full period.
`timescale 1ns/1ps

module swcfg_poll_timer
   import swcfg_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYC_DEF
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // Control
   input  wire logic              run,
   input  wire logic [POLL_W-1:0] code,
   // Result
   output logic                   tick
);

   localparam int unsigned PW = $clog2(MS_CYC + 1);

   if (MS_CYC < 1) begin : g_bad_ms
      $error("MS_CYC must be at least one");
   end

   logic [PW-1:0]   pre_q;
   logic [MS_W-1:0] ms_q;
   logic [MS_W-1:0] period;
   logic            pre_done;
   logic            ms_done;
   logic            tick_q;

   assign period   = swcfg_poll_ms(code);
   assign pre_done = (pre_q == PW'(MS_CYC - 1));
   // A code change mid-period wraps at the end of the current millisecond rather than overrunning
   assign ms_done  = (ms_q >= (period - 8'h01));
   assign tick     = tick_q;

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
      end else if (!run || pre_done) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_q <= '0;
      end else if (!run) begin
         ms_q <= '0;
      end else if (pre_done) begin
         ms_q <= ms_done ? '0 : ms_q + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= run && pre_done && ms_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   a_timer_stopped: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !run |=> !tick_q && (ms_q == '0))
      else $error("poll tick while timer stopped");

   a_tick_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tick_q |-> $past(run) && ($past(ms_q) >= ($past(period) - 8'h01)))
      else $error("poll tick before period end");

endmodule : swcfg_poll_timer

// [src/swcfg_regs.sv]
// Purpose: Serial-reached configuration bank for interrupt enables, poll
//          period, wake-up enables and comparator-only inputs.
// Assumes: Frames of 32 bits, mosi sampled on rising spi_clk, miso moved
//          on falling; spi_clk idles low and runs only inside frames.
// Notes:   Reply to a frame is shifted out during the next frame.
`timescale 1ns/1ps

module swcfg_regs
   import swcfg_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYC_DEF
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // Serial link
   input  wire logic                spi_clk,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_mosi,
   output logic                     spi_miso_o,
   output logic                     spi_miso_oe,
   // Device state and switch events
   input  wire logic                low_power_state,
   input  wire logic                fault_status,
   input  wire logic [GROUND_N-1:0] ground_switch_change,
   input  wire logic [PROG_N-1:0]   programmable_change,
   // Results
   output logic                     pending_interrupt_flag,
   output logic                     wake_req,
   output logic                     poll_tick,
   output logic                     poll_timer_run,
   output logic [PROG_N-1:0]        cmp_only_active
);

   if (GROUND_N > DATA_W || PROG_N > DATA_W) begin : g_bad_width
      $error("register fields wider than frame data");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain

   logic                 frame_rst;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [FRAME_W-1:0]   rx_sh_q;
   swcfg_frame_t         rx_word_q;
   logic                 rx_tgl_q;
   logic [FRAME_W-1:0]   tx_sh_q;
   logic                 tx_act_q;
   swcfg_frame_t         tx_word_q;

   // Deselect clears the frame position; a short frame is dropped
   assign frame_rst = !rst_n || spi_cs_n;

   always_ff @(posedge spi_clk or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_q <= FIRST_BIT;
      end else begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_q <= '0;
      end else if (!spi_cs_n) begin
         rx_sh_q <= {rx_sh_q[FRAME_W-2:0], spi_mosi};
      end
   end

   // Word held until the next full frame, so the toggle guards it
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word_q <= '0;
         rx_tgl_q  <= 1'b0;
      end else if (!spi_cs_n && bit_cnt_q == LAST_BIT) begin
         rx_word_q <= {rx_sh_q[FRAME_W-2:0], spi_mosi};
         rx_tgl_q  <= !rx_tgl_q;
      end
   end

   // Reply word is quasi-static here: built long before the next frame
   always_ff @(negedge spi_clk or posedge frame_rst) begin
      if (frame_rst) begin
         tx_sh_q  <= '0;
         tx_act_q <= 1'b0;
      end else if (!tx_act_q) begin
         tx_sh_q  <= {tx_word_q[FRAME_W-2:0], 1'b0};
         tx_act_q <= 1'b1;
      end else begin
         tx_sh_q  <= {tx_sh_q[FRAME_W-2:0], 1'b0};
      end
   end

   assign spi_miso_o  = tx_act_q ? tx_sh_q[FRAME_W-1] : tx_word_q[FRAME_W-1];
   assign spi_miso_oe = !spi_cs_n;

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the reference domain

   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic rx_take;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= rx_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   assign rx_take = tgl_s2_q ^ tgl_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [GROUND_N-1:0] ground_irq_en_q,   ground_irq_en_d;
   logic [PROG_N-1:0]   prog_irq_en_q,     prog_irq_en_d;
   logic [POLL_W-1:0]   poll_code_q,       poll_code_d;
   logic [PROG_N-1:0]   prog_wake_q,       prog_wake_d;
   logic [GROUND_N-1:0] ground_wake_q,     ground_wake_d;
   logic [PROG_N-1:0]   prog_cmp_only_q,   prog_cmp_only_d;
   logic                wr_cmd;
   logic [DATA_W-1:0]   rd_data;

   assign wr_cmd = rx_take && (rx_word_q.wr == TYPE_WRITE);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return a == off[7:1];
   endfunction : hit

   always_comb begin
      ground_irq_en_d = ground_irq_en_q;
      prog_irq_en_d   = prog_irq_en_q;
      poll_code_d     = poll_code_q;
      prog_wake_d     = prog_wake_q;
      ground_wake_d   = ground_wake_q;
      prog_cmp_only_d = prog_cmp_only_q;
      if (wr_cmd) begin
         if (hit(rx_word_q.addr, OFF_GROUND_IRQ_EN)) begin
            ground_irq_en_d = rx_word_q.data[GROUND_N-1:0];
         end
         if (hit(rx_word_q.addr, OFF_PROG_IRQ_EN)) begin
            prog_irq_en_d = rx_word_q.data[PROG_N-1:0];
         end
         // poll code taken in any state
         if (hit(rx_word_q.addr, OFF_POLL_CFG)) begin
            poll_code_d = rx_word_q.data[POLL_W-1:0];
         end
         if (hit(rx_word_q.addr, OFF_PROG_WAKE)) begin
            prog_wake_d = rx_word_q.data[PROG_N-1:0];
         end
         if (hit(rx_word_q.addr, OFF_GROUND_WAKE)) begin
            ground_wake_d = rx_word_q.data[GROUND_N-1:0];
         end
         if (hit(rx_word_q.addr, OFF_PROG_CMP_ONLY)) begin
            prog_cmp_only_d = rx_word_q.data[PROG_N-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ground_irq_en_q <= RST_GROUND_IRQ_EN;
         prog_irq_en_q   <= RST_PROG_IRQ_EN;
      end else begin
         ground_irq_en_q <= ground_irq_en_d;
         prog_irq_en_q   <= prog_irq_en_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         poll_code_q     <= RST_POLL_CODE;
         prog_cmp_only_q <= RST_PROG_CMP_ONLY;
      end else begin
         poll_code_q     <= poll_code_d;
         prog_cmp_only_q <= prog_cmp_only_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_wake_q   <= RST_PROG_WAKE;
         ground_wake_q <= RST_GROUND_WAKE;
      end else begin
         prog_wake_q   <= prog_wake_d;
         ground_wake_q <= ground_wake_d;
      end
   end

   // unused upper bits read zero; unmapped reads zero
   always_comb begin
      rd_data = '0;
      if (hit(rx_word_q.addr, OFF_GROUND_IRQ_EN)) begin
         rd_data[GROUND_N-1:0] = ground_irq_en_d;
      end else if (hit(rx_word_q.addr, OFF_PROG_IRQ_EN)) begin
         rd_data[PROG_N-1:0] = prog_irq_en_d;
      end else if (hit(rx_word_q.addr, OFF_POLL_CFG)) begin
         rd_data[POLL_W-1:0] = poll_code_d;
      end else if (hit(rx_word_q.addr, OFF_PROG_WAKE)) begin
         rd_data[PROG_N-1:0] = prog_wake_d;
      end else if (hit(rx_word_q.addr, OFF_GROUND_WAKE)) begin
         rd_data[GROUND_N-1:0] = ground_wake_d;
      end else if (hit(rx_word_q.addr, OFF_PROG_CMP_ONLY)) begin
         rd_data[PROG_N-1:0] = prog_cmp_only_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status and reply

   logic pend_q;
   logic pend_set;

   assign pend_set = |(ground_switch_change & ground_irq_en_q)
                   || |(programmable_change & prog_irq_en_q);

   // enabled change raises flag, set beats clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_set || (pend_q && !rx_take);
      end
   end

   assign pending_interrupt_flag = pend_q;

   // fault and pending flag in reply
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_q <= '0;
      end else if (rx_take) begin
         tx_word_q.addr  <= rx_word_q.addr;
         tx_word_q.wr    <= rx_word_q.wr;
         tx_word_q.fault <= fault_status;
         tx_word_q.pend  <= pend_q;
         tx_word_q.data  <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Low-power behaviour

   logic                wake_q;
   logic                wake_any;
   logic [PROG_N-1:0]   cmp_act_q;

   assign wake_any       = |prog_wake_q || |ground_wake_q;
   assign poll_timer_run = low_power_state && wake_any;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= low_power_state && (|(programmable_change & prog_wake_q)
                                    || |(ground_switch_change & ground_wake_q));
      end
   end

   // comparator-only only acts in low power
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_act_q <= '0;
      end else begin
         cmp_act_q <= low_power_state ? prog_cmp_only_q : '0;
      end
   end

   assign wake_req        = wake_q;
   assign cmp_only_active = cmp_act_q;

   swcfg_poll_timer #(
      .MS_CYC (MS_CYC)
   ) u_poll_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .run     (poll_timer_run),
      .code    (poll_code_q),
      .tick    (poll_tick)
   );

   ////////////////////////////////////////////////////////////////////////////

   a_irq_set_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(ground_switch_change & ground_irq_en_q)) |=> pend_q)
      else $error("enabled ground change did not set flag");

   a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pend_q && !(|(programmable_change & prog_irq_en_q))
      && !(|(ground_switch_change & ground_irq_en_q)) |=> !pend_q)
      else $error("flag set without enabled change");

   a_reply_echo: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_take |=> tx_word_q.addr == $past(rx_word_q.addr)
                  && tx_word_q.wr == $past(rx_word_q.wr))
      else $error("reply address or type differs");

   a_reply_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_take |=> tx_word_q.fault == $past(fault_status) && tx_word_q.pend == $past(pend_q))
      else $error("reply status bits wrong");

   a_poll_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_cmd && hit(rx_word_q.addr, OFF_POLL_CFG)
      |=> poll_code_q == $past(rx_word_q.data[POLL_W-1:0]) && tx_word_q.data[DATA_W-1:POLL_W] == '0)
      else $error("poll code write lost");

   a_wake_ground: assert property (@(posedge ref_clk) disable iff (!rst_n)
      low_power_state && |(ground_switch_change & ground_wake_q) |=> wake_q)
      else $error("enabled ground change did not wake");

   a_wake_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !low_power_state || !(|(programmable_change & prog_wake_q)
      || |(ground_switch_change & ground_wake_q)) |=> !wake_q)
      else $error("wake without enabled change");

   a_timer_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !wake_any |=> !poll_tick)
      else $error("poll tick with no wake source");

   a_cmp_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !low_power_state |=> cmp_act_q == '0)
      else $error("comparator-only active outside low power");

endmodule : swcfg_regs

// [sim/swcfg_host.sv]
// Purpose: Host-side serial controller model sending 32-bit frames.
// Assumes: Mode 0; clock idles low, 48 ns period, runs only inside frames.
// Notes:   Gap after each frame leaves the reply time to settle.
`timescale 1ns/1ps

module swcfg_host (
   // Serial link
   output logic      spi_clk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   localparam time HALF = 24ns;

   initial begin
      spi_clk  = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      spi_cs_n <= 1'b0;
      spi_mosi <= tx[31];
      #HALF;
      for (int k = 0; k < 32; k++) begin
         spi_clk <= 1'b1;
         rx[31-k] = spi_miso;
         #HALF;
         spi_clk <= 1'b0;
         if (k < 31) begin
            spi_mosi <= tx[30-k];
         end
         #HALF;
      end
      // Released data line shows the inverse, not a stale bit
      spi_cs_n <= 1'b1;
      spi_mosi <= ~tx[0];
      #400ns;
   endtask : xfer
endmodule : swcfg_host

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the switch configuration bank.
// Assumes: 40 MHz reference clock, host model on the serial link.
// Notes:   Poll timebase shortened to 4 cycles per millisecond.
`timescale 1ns/1ps

module tb_top;
   import swcfg_pkg::*;
   localparam int unsigned MSC = 4;
   typedef struct packed {
      logic [31:0] cmd;
      logic [21:0] dat;
   } swcfg_row_t;

   logic                ref_clk;
   logic                rst_n;
   logic                spi_clk;
   logic                spi_cs_n;
   logic                spi_mosi;
   logic                miso_o;
   logic                miso_oe;
   logic                low_power_state;
   logic                fault_status;
   logic [GROUND_N-1:0] ground_change;
   logic [PROG_N-1:0]   prog_change;
   logic                pend;
   logic                wake_req;
   logic                poll_tick;
   logic                poll_run;
   logic [PROG_N-1:0]   cmp_only;
   logic [31:0]         rx;
   logic [31:0]         exp_q;
   int                  fail_count;
   int                  cmp_count;
   int                  wake_cnt;
   int                  tick_cnt;
   int                  tick_ctr;
   int                  tick_gap;
   int                  base;
   wire logic           spi_miso = miso_oe ? miso_o : ~spi_mosi;

   logic [7:0] ms_tab [16] = '{8'h03, 8'h06, 8'h0C, 8'h18, 8'h30, 8'h44, 8'h4C, 8'h80,
                               8'h20, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h34, 8'h38, 8'h40};
   swcfg_row_t rows [13] = '{
      '{32'h1C00_0000, 22'h3FFF}, '{32'h1A00_0000, 22'hFF}, '{32'h1E00_0000, 22'hF},
      '{32'h2000_0000, 22'hFF},   '{32'h2200_0000, 22'h3FFF}, '{32'h2400_0000, 22'h0},
      '{32'h1F3F_FFF5, 22'h5},    '{32'h1D00_0000, 22'h0},  '{32'h6000_0000, 22'h0},
      '{32'h2400_00AA, 22'h0},    '{32'h2500_00A5, 22'hA5}, '{32'h2100_0000, 22'h0},
      '{32'h23C0_0000, 22'h0}};

   swcfg_regs #(.MS_CYC(MSC)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
      .low_power_state(low_power_state), .fault_status(fault_status),
      .ground_switch_change(ground_change), .programmable_change(prog_change),
      .pending_interrupt_flag(pend), .wake_req(wake_req), .poll_tick(poll_tick),
      .poll_timer_run(poll_run), .cmp_only_active(cmp_only));

   swcfg_host u_host (
      .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Event monitors: wake count, tick count and tick spacing
   always @(posedge ref_clk) begin
      if (wake_req === 1'b1) wake_cnt++;
      if (poll_tick === 1'b1) begin
         tick_cnt++;
         tick_gap = tick_ctr;
         tick_ctr = 1;
      end else begin
         tick_ctr++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   // Reply to a frame arrives during the next one
   task automatic send(input logic [31:0] cmd, input logic [21:0] dat, input logic pnd);
      @(posedge ref_clk);
      u_host.xfer(cmd, rx);
      check(rx, exp_q);
      exp_q = {cmd[31:24], fault_status, pnd, dat};
   endtask : send

   task automatic pulse(input logic [13:0] g, input logic [7:0] p);
      @(posedge ref_clk);
      ground_change <= g;
      prog_change   <= p;
      @(posedge ref_clk);
      ground_change <= '0;
      prog_change   <= '0;
      repeat (4) @(posedge ref_clk);
   endtask : pulse

   task automatic lp(input logic v);
      @(posedge ref_clk);
      low_power_state <= v;
      repeat (3) @(posedge ref_clk);
   endtask : lp

   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1ms;
      fail_count++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      low_power_state = 1'b0;
      fault_status = 1'b0;
      ground_change = '0;
      prog_change = '0;
      exp_q = 32'h0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         @(posedge ref_clk);
         fault_status <= i[0];
         send(rows[i].cmd, rows[i].dat, 1'b0);
      end
      check({31'h0, miso_oe}, 32'h0);
      pulse(14'h0001, 8'h00);
      check({31'h0, pend}, 32'h0);
      pulse(14'h0000, 8'h08);
      check({31'h0, pend}, 32'h1);
      send(32'h1C00_0000, 22'h0, 1'b1);
      repeat (6) @(posedge ref_clk);
      check({31'h0, pend}, 32'h0);
      check({24'h0, cmp_only}, 32'h0);
      lp(1'b1);
      check({31'h0, poll_run}, 32'h0);
      base = tick_cnt;
      pulse(14'h3FFF, 8'hFF);
      repeat (600) @(posedge ref_clk);
      check(32'(tick_cnt - base), 32'h0);
      check(32'(wake_cnt), 32'h0);
      check({24'h0, cmp_only}, 32'hA5);
      // wake enables written in normal mode only
      lp(1'b0);
      send(32'h2100_0008, 22'h08, 1'b1);
      send(32'h2300_2000, 22'h2000, 1'b0);
      lp(1'b1);
      check({31'h0, poll_run}, 32'h1);
      pulse(14'h1000, 8'h04);
      check(32'(wake_cnt), 32'h0);
      pulse(14'h2000, 8'h00);
      check(32'(wake_cnt), 32'h1);
      pulse(14'h0000, 8'h08);
      check(32'(wake_cnt), 32'h2);
      // every poll code, spacing of ticks
      for (int c = 0; c < 16; c++) begin
         send({8'h1F, 20'h0, 4'(c)}, 22'(c), c == 0);
         base = tick_cnt;
         for (int n = 0; n < 3000 && tick_cnt < base + 3; n++) @(posedge ref_clk);
         check(32'(tick_gap), 32'(ms_tab[c]) * MSC);
      end
      // Second reset in mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      exp_q = 32'h0;
      send(32'h1E00_0000, 22'hF, 1'b0);
      send(32'h2200_0000, 22'h3FFF, 1'b0);
      send(32'h1A00_0000, 22'hFF, 1'b0);
      pulse(14'h0004, 8'h00);
      check({31'h0, pend}, 32'h1);
      send(32'h1C00_0000, 22'h3FFF, 1'b1);
      conclude();
   end
endmodule : tb_top
